// ==== frs_pkg.sv ====
// Shared constants and types for the result status byte generator
package frs_pkg;

    // ------------------------------------------------------------------
    // Register offsets and bus codes
    // ------------------------------------------------------------------
    localparam logic [2:0] FRS_FIFO_OFS    = 3'h5;
    localparam logic [7:0] FRS_INVALID_ST0 = 8'h80;
    localparam logic [7:0] FRS_BAD_TRACK   = 8'hff;

    // ------------------------------------------------------------------
    // Status byte zero fields
    // ------------------------------------------------------------------
    localparam int S0_DRV   = 0;
    localparam int S0_HEAD  = 2;
    localparam int S0_EQUIP = 4;
    localparam int S0_SEEK  = 5;
    localparam int S0_IC    = 6;

    // ------------------------------------------------------------------
    // Status byte one fields
    // ------------------------------------------------------------------
    localparam int S1_MAM  = 0;
    localparam int S1_WP   = 1;
    localparam int S1_MD   = 2;
    localparam int S1_OR   = 4;
    localparam int S1_CRC  = 5;
    localparam int S1_EOT  = 7;

    // ------------------------------------------------------------------
    // Status byte two fields
    // ------------------------------------------------------------------
    localparam int S2_MAML = 0;
    localparam int S2_BT   = 1;
    localparam int S2_SNS  = 2;
    localparam int S2_SS   = 3;
    localparam int S2_WT   = 4;
    localparam int S2_CRCD = 5;
    localparam int S2_CM   = 6;

    // Result byte count for a full status readout
    localparam logic [1:0] FRS_NBYTES = 2'h3;

    // Interrupt cause codes
    typedef enum logic [1:0] {
        IC_NORMAL  = 2'b00,
        IC_ABNORM  = 2'b01,
        IC_INVALID = 2'b10,
        IC_POLL    = 2'b11
    } frs_ic_t;

    // Result sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RESULT
    } frs_state_t;

endpackage : frs_pkg

// ==== frs_cond_if.sv ====
// Interface carrying latched execution conditions between modules
`timescale 1ns/1ps
interface frs_cond_if;
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    logic       valid;
    modport src (output st0, output st1, output st2, output valid);
    modport dst (input st0, input st1, input st2, input valid);
endinterface : frs_cond_if

// ==== frs_sync.sv ====
// Two flip-flop synchroniser for pin levels, one per bit
`timescale 1ns/1ps
module frs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] m_q;

    // --------------------------------------------------------------
    // Synchroniser chain; first stage read only by the second
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_q <= '0;
            q   <= '0;
        end else if (ce) begin
            m_q <= d;
            q   <= m_q;
        end
    end
endmodule : frs_sync

// ==== frs_latch.sv ====
// Latches the three composed status bytes at end of execution
`timescale 1ns/1ps
module frs_latch (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       exec_end,
    input  wire logic       consumed,
    input  wire logic [7:0] st0_d,
    input  wire logic [7:0] st1_d,
    input  wire logic [7:0] st2_d,
    frs_cond_if.src         cond
);
    logic [7:0] s0_q, s1_q, s2_q;
    logic [7:0] s0_d, s1_d, s2_d;
    logic       v_q, v_d;

    // --------------------------------------------------------------
    // Capture on end of execution, hold until the host consumes
    // --------------------------------------------------------------
    always_comb begin
        s0_d = s0_q;
        s1_d = s1_q;
        s2_d = s2_q;
        v_d  = v_q;
        if (consumed)
            v_d = 1'b0;
        if (exec_end) begin
            s0_d = st0_d;
            s1_d = st1_d;
            s2_d = st2_d;
            v_d  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s0_q <= 8'h00;
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            v_q  <= 1'b0;
        end else if (ce) begin
            s0_q <= s0_d;
            s1_q <= s1_d;
            s2_q <= s2_d;
            v_q  <= v_d;
        end
    end

    assign cond.st0   = s0_q;
    assign cond.st1   = s1_q;
    assign cond.st2   = s2_q;
    assign cond.valid = v_q;
endmodule : frs_latch

// ==== frs_status.sv ====
// Result phase status byte generator, top level
`timescale 1ns/1ps
// Behaviour
// - Byte zero bits 1:0 give drive selected
// - Byte zero bit 2 gives head side
// - Unused status bits always read zero
// - Homing without track zero sets equipment check
// - Seek or homing completion sets seek end
// - Bits 7:6 encode interrupt cause
// - Cause 11 only on polling ready change
// - Byte one bit 0 missing address mark
// - Byte one bit 1 write protect on writes
// - Byte one bit 2 missing data cases
// - Byte one bit 4 overrun or underrun
// - Byte one bit 5 on CRC failure
// - Byte one bit 7 end of track
// - Byte two bit 0 locates missing mark
// - Byte two bit 1 bad track FFh
// - Byte two bit 2 scan not satisfied
// - Byte two bit 3 scan equal found
// - Byte two bit 4 wrong track
// - Byte two bit 5 data field CRC
// - Byte two bit 6 control mark seen
// - Bytes read from FIFO offset 05h only
// - Invalid opcode returns 80h at once
module frs_status
    import frs_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // Execution engine, same clock
    input  wire logic       exec_end,
    input  wire logic       invalid_cmd,
    input  wire logic       poll_change,
    input  wire logic       abnormal,
    input  wire logic [1:0] drive_sel,
    input  wire logic       head_side_select,
    input  wire logic       homing_cmd,
    input  wire logic       seek_done,
    input  wire logic       write_cmd,
    input  wire logic       scan_cmd,
    input  wire logic       miss_am,
    input  wire logic       miss_am_data,
    input  wire logic       miss_data,
    input  wire logic       overrun,
    input  wire logic       crc_err,
    input  wire logic       crc_in_data,
    input  wire logic       eot_reached,
    input  wire logic       sector_nf,
    input  wire logic [7:0] rec_track,
    input  wire logic [7:0] cmd_track,
    input  wire logic       scan_fail,
    input  wire logic       scan_equal,
    input  wire logic       ctrl_mark,
    // Drive pins, asynchronous
    input  wire logic       track_zero_input,
    input  wire logic       write_protect_b,
    input  wire logic       terminal_count_input,
    // Host read port
    input  wire logic       rd_b,
    input  wire logic       cs_b,
    input  wire logic [2:0] addr,
    output logic      [7:0] rd_data,
    output logic            request_for_master,
    output logic            direction_to_host,
    output logic            result_phase
);
    import frs_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_m_q, rst_n;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_n   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n   <= rst_m_q;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [7:0] pin_s;

    // Address is synced too, so it keeps step with the strobes
    frs_sync #(.W(8)) u_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .ce    (clk_en),
        .d     ({addr, track_zero_input, ~write_protect_b,
                 terminal_count_input, ~rd_b, ~cs_b}),
        .q     (pin_s)
    );

    logic [2:0] addr_s;
    logic       track_zero_input_s, wp_s, tc_s, rd_s, cs_s;
    assign {addr_s, track_zero_input_s, wp_s, tc_s, rd_s, cs_s} = pin_s;

    // ------------------------------------------------------------------
    // Track-zero and terminal count seen during execution
    // ------------------------------------------------------------------
    logic track_zero_input_seen_q, track_zero_input_seen_d, tc_seen_q, tc_seen_d;

    // Sticky so a short pulse mid-command is not lost by end time
    always_comb begin
        track_zero_input_seen_d = track_zero_input_seen_q | track_zero_input_s;
        tc_seen_d   = tc_seen_q | tc_s;
        if (exec_end) begin
            track_zero_input_seen_d = 1'b0;
            tc_seen_d   = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            track_zero_input_seen_q <= 1'b0;
            tc_seen_q   <= 1'b0;
        end else if (clk_en) begin
            track_zero_input_seen_q <= track_zero_input_seen_d;
            tc_seen_q   <= tc_seen_d;
        end
    end

    // ------------------------------------------------------------------
    // Polling cause permitted only after reset until first command ending without a polling change
    // ------------------------------------------------------------------
    logic poll_ok_q, poll_ok_d;

    always_comb begin
        poll_ok_d = poll_ok_q;
        if (exec_end && !poll_change)
            poll_ok_d = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            poll_ok_q <= 1'b1;
        else if (clk_en)
            poll_ok_q <= poll_ok_d;
    end

    // ------------------------------------------------------------------
    // Compose status bytes
    // ------------------------------------------------------------------
    logic [7:0] st0_c, st1_c, st2_c;
    frs_ic_t    ic;
    logic       track_zero_input_any;

    always_comb begin
        track_zero_input_any = track_zero_input_seen_q | track_zero_input_s;
        st0_c = 8'h00;
        st1_c = 8'h00;
        st2_c = 8'h00;
        // Invalid wins, polling only in its reset window
        if (invalid_cmd)
            ic = IC_INVALID;
        else if (poll_change && poll_ok_q)
            ic = IC_POLL;
        else if (abnormal)
            ic = IC_ABNORM;
        else
            ic = IC_NORMAL;
        st0_c[S0_IC+:2]  = ic;
        st0_c[S0_DRV+:2] = drive_sel;
        st0_c[S0_HEAD]   = head_side_select;
        st0_c[S0_EQUIP]  = homing_cmd & ~track_zero_input_any;
        st0_c[S0_SEEK]   = seek_done;
        if (invalid_cmd)
            st0_c = FRS_INVALID_ST0;
        st1_c[S1_MAM] = miss_am & ~write_cmd;
        st1_c[S1_WP]  = write_cmd & wp_s;
        st1_c[S1_MD]  = miss_data;
        st1_c[S1_OR]  = overrun;
        st1_c[S1_CRC] = crc_err;
        st1_c[S1_EOT] = eot_reached & ~(tc_seen_q | tc_s);
        st2_c[S2_MAML] = miss_am & ~write_cmd & miss_am_data;
        st2_c[S2_BT]   = sector_nf && rec_track == FRS_BAD_TRACK
                         && rec_track != cmd_track;
        st2_c[S2_SNS]  = scan_cmd & scan_fail;
        st2_c[S2_SS]   = scan_cmd & scan_equal;
        st2_c[S2_WT]   = sector_nf && rec_track != cmd_track;
        st2_c[S2_CRCD] = crc_err & crc_in_data;
        st2_c[S2_CM]   = ctrl_mark;
        if (invalid_cmd) begin
            st1_c = 8'h00;
            st2_c = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Latch at end of execution
    // ------------------------------------------------------------------
    frs_cond_if cond ();
    logic consumed;

    frs_latch u_latch (
        .clk      (ref_clk),
        .rst_n    (rst_n),
        .ce       (clk_en),
        .exec_end (exec_end),
        .consumed (consumed),
        .st0_d    (st0_c),
        .st1_d    (st1_c),
        .st2_d    (st2_c),
        .cond     (cond.src)
    );

    // ------------------------------------------------------------------
    // Result readout sequencer
    // ------------------------------------------------------------------
    frs_state_t state_q, state_d;
    logic [1:0] idx_q, idx_d, nbytes_q, nbytes_d;
    logic       rd_prev_q, rd_fire;
    logic [7:0] data_q, data_d;

    // Read taken on the falling edge of the synchronised strobe
    assign rd_fire = rd_prev_q & ~(rd_s & cs_s) & (addr_s == FRS_FIFO_OFS);

    always_comb begin
        state_d  = state_q;
        idx_d    = idx_q;
        nbytes_d = nbytes_q;
        data_d   = data_q;
        consumed = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (exec_end) begin
                    state_d  = ST_RESULT;
                    idx_d    = 2'h0;
                    nbytes_d = invalid_cmd ? 2'h1 : FRS_NBYTES;
                end
            end
            ST_RESULT: begin
                if (rd_fire) begin
                    idx_d = idx_q + 2'h1;
                    if (idx_q + 2'h1 == nbytes_q) begin
                        state_d  = ST_IDLE;
                        consumed = 1'b1;
                    end
                end
            end
        endcase
        // Data register follows the byte index
        unique case (idx_d)
            2'h0:    data_d = cond.st0;
            2'h1:    data_d = cond.st1;
            default: data_d = cond.st2;
        endcase
        if (state_d == ST_IDLE)
            data_d = 8'h00;
        if (exec_end)
            data_d = st0_c;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= ST_IDLE;
            idx_q     <= 2'h0;
            nbytes_q  <= 2'h0;
            rd_prev_q <= 1'b0;
            data_q    <= 8'h00;
        end else if (clk_en) begin
            state_q   <= state_d;
            idx_q     <= idx_d;
            nbytes_q  <= nbytes_d;
            rd_prev_q <= rd_s & cs_s & (addr_s == FRS_FIFO_OFS);
            data_q    <= data_d;
        end
    end

    assign rd_data            = data_q;
    assign result_phase       = (state_q == ST_RESULT);
    assign request_for_master = (state_q == ST_RESULT);
    assign direction_to_host  = (state_q == ST_RESULT);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_unused_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        cond.valid |-> !cond.st0[3] && !cond.st1[3] && !cond.st1[6]
                       && !cond.st2[7];
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused status bit set");

    property p_invalid;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && exec_end && invalid_cmd) |=> cond.st0 == 8'h80;
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("invalid opcode status not 80h");

    property p_drive;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && exec_end && !invalid_cmd)
            |=> cond.st0[1:0] == $past(drive_sel);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive field mismatch");

    property p_head;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && exec_end && !invalid_cmd)
            |=> cond.st0[2] == $past(head_side_select);
    endproperty
    a_head: assert property (p_head)
        else $error("head field mismatch");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (result_phase && !exec_end) |=> $stable(cond.st1) || exec_end;
    endproperty
    a_hold: assert property (p_hold)
        else $error("status changed during result phase");

    property p_dir;
        @(posedge ref_clk) disable iff (!rst_n)
        direction_to_host |-> request_for_master && result_phase
                              && cond.valid;
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction without result phase");

    property p_crcd;
        @(posedge ref_clk) disable iff (!rst_n)
        cond.valid && cond.st2[5] |-> cond.st1[5];
    endproperty
    a_crcd: assert property (p_crcd)
        else $error("data CRC flag without CRC error");

    property p_maml;
        @(posedge ref_clk) disable iff (!rst_n)
        cond.valid && cond.st2[0] |-> cond.st1[0];
    endproperty
    a_maml: assert property (p_maml)
        else $error("mark location without missing mark");

    property p_enter;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && exec_end && !result_phase)
            |=> result_phase && rd_data == cond.st0;
    endproperty
    a_enter: assert property (p_enter)
        else $error("result phase not entered with byte zero");
endmodule : frs_status

// ==== frs_host.sv ====
// Host processor model that reads result bytes from the data port
`timescale 1ns/1ps
module frs_host (
    input  wire logic       ref_clk,
    input  wire logic       request_for_master,
    input  wire logic       direction_to_host,
    input  wire logic [7:0] rd_data,
    output logic            rd_b,
    output logic            cs_b,
    output logic      [2:0] addr
);
    // Strobes idle high; address shows a non-matching pattern
    initial begin
        rd_b = 1'b1;
        cs_b = 1'b1;
        addr = 3'h2;
    end

    // ------------------------------------------------------------------
    // One read cycle, called just after a falling edge
    // ------------------------------------------------------------------
    task automatic read_byte(input  logic [2:0] a,
                             input  logic       chk,
                             output logic [7:0] b,
                             output logic       ok);
        int n;
        n = 0;
        ok = 1'b1;
        b = 8'h00;
        // Both flags must be up before each byte when chk is set
        while (ok && chk && !(request_for_master && direction_to_host))
        begin
            @(negedge ref_clk);
            n++;
            if (n > 50) ok = 1'b0;
        end
        if (ok) begin
            b = rd_data;        // Byte stands until the strobe ends
            addr = a;
            cs_b = 1'b0;
            rd_b = 1'b0;
            repeat (4) @(negedge ref_clk);
            rd_b = 1'b1;
            cs_b = 1'b1;
            // Address held past the strobe, synced copies lag
            repeat (4) @(negedge ref_clk);
            addr = ~a;
            // Let an edge pass so a next call never reassigns at once
            @(negedge ref_clk);
        end
    endtask : read_byte
endmodule : frs_host

// ==== frs_status_tb_top.sv ====
// Self-checking bench for the result status byte generator
`timescale 1ns/1ps
module frs_status_tb_top;
    import frs_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        ref_clk, rst_b, clk_en, exec_end;
    logic        invalid_cmd, poll_change, abnormal, homing_cmd, seek_done;
    logic        write_cmd, scan_cmd, miss_am, miss_am_data, miss_data;
    logic        overrun, crc_err, crc_in_data, eot_reached, sector_nf;
    logic        scan_fail, scan_equal, ctrl_mark, head_side_select;
    logic        track_zero_input, write_protect_b, terminal_count_input;
    logic        rd_b, cs_b, request_for_master, direction_to_host;
    logic        result_phase;
    logic [1:0]  drive_sel;
    logic [2:0]  addr;
    logic [7:0]  rec_track, cmd_track, rd_data;
    logic [17:0] flg;
    int          num_errors;
    int          checked;

    // Condition masks, one bit per source into flg
    localparam logic [17:0] CTM = 18'h00001, SEQ = 18'h00002;
    localparam logic [17:0] SFL = 18'h00004, SNF = 18'h00008;
    localparam logic [17:0] EOT = 18'h00010, CRD = 18'h00020;
    localparam logic [17:0] CRC = 18'h00040, OVR = 18'h00080;
    localparam logic [17:0] MDT = 18'h00100, MAD = 18'h00200;
    localparam logic [17:0] MAM = 18'h00400, SCN = 18'h00800;
    localparam logic [17:0] WRC = 18'h01000, SKD = 18'h02000;
    localparam logic [17:0] HOM = 18'h04000, ABN = 18'h08000;
    localparam logic [17:0] PCH = 18'h10000, INV = 18'h20000;

    assign {invalid_cmd, poll_change, abnormal, homing_cmd, seek_done,
            write_cmd, scan_cmd, miss_am, miss_am_data, miss_data, overrun,
            crc_err, crc_in_data, eot_reached, sector_nf, scan_fail,
            scan_equal, ctrl_mark} = flg;

    frs_status uut (
        .ref_clk, .rst_b, .clk_en, .exec_end, .invalid_cmd, .poll_change,
        .abnormal, .drive_sel, .head_side_select, .homing_cmd, .seek_done,
        .write_cmd, .scan_cmd, .miss_am, .miss_am_data, .miss_data,
        .overrun, .crc_err, .crc_in_data, .eot_reached, .sector_nf,
        .rec_track, .cmd_track, .scan_fail, .scan_equal, .ctrl_mark,
        .track_zero_input, .write_protect_b, .terminal_count_input,
        .rd_b, .cs_b, .addr, .rd_data, .request_for_master,
        .direction_to_host, .result_phase
    );

    frs_host host (
        .ref_clk, .request_for_master, .direction_to_host, .rd_data,
        .rd_b, .cs_b, .addr
    );

    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask : check

    // Read wrapper; an expired wait ends the run
    task automatic rd(input logic [2:0] a, input logic chk,
                      output logic [7:0] b);
        logic ok;
        host.read_byte(a, chk, b, ok);
        if (!ok) begin
            $display("[ERR] ready wait expired");
            num_errors++;
            end_sim();
        end
    endtask : rd

    // One command: set sources, end execution, read n bytes back
    task automatic run(input logic [17:0] f, input logic [1:0] d,
                       input logic h, input logic [2:0] p,
                       input logic [7:0] rt, ct, e0, e1, e2,
                       input int n);
        logic [7:0] b;
        logic [7:0] e [3];
        e = '{e0, e1, e2};
        flg = f;
        drive_sel = d;
        head_side_select = h;
        rec_track = rt;
        cmd_track = ct;
        write_protect_b = ~p[1];
        track_zero_input = p[0];
        terminal_count_input = p[2];
        repeat (4) @(negedge ref_clk);
        // Pin pulses end early; they must be remembered
        track_zero_input = 1'b0;
        terminal_count_input = 1'b0;
        repeat (2) @(negedge ref_clk);
        exec_end = 1'b1;
        @(negedge ref_clk);
        exec_end = 1'b0;
        // Scramble sources so a non-latching design shows up
        flg = ~f;
        drive_sel = ~d;
        head_side_select = ~h;
        rec_track = ~rt;
        cmd_track = ~ct;
        write_protect_b = p[1];
        rd(3'h3, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            rd(FRS_FIFO_OFS, 1'b1, b);
            check("status byte", b, e[i]);
        end
        repeat (3) @(negedge ref_clk);
        check("phase flags after readout",
              {5'h0, result_phase, request_for_master, direction_to_host},
              8'h00);
        check("data after readout", rd_data, 8'h00);
        rd(FRS_FIFO_OFS, 1'b0, b);
        check("phase after idle read", {7'h0, result_phase}, 8'h00);
    endtask : run

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        exec_end = 1'b0;
        flg = '0;
        drive_sel = 2'h0;
        head_side_select = 1'b0;
        rec_track = 8'h00;
        cmd_track = 8'h00;
        track_zero_input = 1'b0;
        write_protect_b = 1'b1;
        terminal_count_input = 1'b0;
        num_errors = 0;
        checked = 0;
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        // Polling cause is legal only until a command ends without a polling change
        run(PCH, 2'h1, 1'b0, 3'h0, 8'h00, 8'h00,
            8'hc1, 8'h00, 8'h00, 3);
        run(SKD, 2'h3, 1'b1, 3'h0, 8'h00, 8'h00,
            8'h27, 8'h00, 8'h00, 3);
        run(ABN | HOM | SKD | MAM | CRC, 2'h2, 1'b0, 3'h0, 8'h00, 8'h00,
            8'h72, 8'h21, 8'h00, 3);
        run(HOM | SKD, 2'h1, 1'b0, 3'h1, 8'h00, 8'h00,
            8'h21, 8'h00, 8'h00, 3);
        run(ABN | MAM | MAD | OVR | CRC | CRD | CTM, 2'h0, 1'b0, 3'h0,
            8'h00, 8'h00, 8'h40, 8'h31, 8'h61, 3);
        run(ABN | WRC | MDT | EOT | SNF, 2'h0, 1'b0, 3'h2, 8'hff, 8'h10,
            8'h40, 8'h86, 8'h12, 3);
        run(WRC | EOT | SNF, 2'h0, 1'b0, 3'h4, 8'h20, 8'h21,
            8'h00, 8'h00, 8'h10, 3);
        run(ABN | HOM | SKD | SCN | MAM | MAD | MDT | OVR | CRC | CRD | EOT
            | SNF | SFL | SEQ | CTM, 2'h3, 1'b1, 3'h2, 8'hff, 8'h00,
            8'h77, 8'hb5, 8'h7f, 3);
        run(ABN | PCH, 2'h2, 1'b0, 3'h0, 8'h00, 8'h00,
            8'h42, 8'h00, 8'h00, 3);
        // Frozen clock enable must ignore an end of execution
        clk_en = 1'b0;
        exec_end = 1'b1;
        @(negedge ref_clk);
        exec_end = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("phase while frozen", {7'h0, result_phase}, 8'h00);
        clk_en = 1'b1;
        // Mid-run reset opens the polling window again
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        run(PCH, 2'h3, 1'b0, 3'h0, 8'h00, 8'h00,
            8'hc3, 8'h00, 8'h00, 3);
        run(INV, 2'h2, 1'b1, 3'h0, 8'h00, 8'h00,
            8'h80, 8'h00, 8'h00, 1);
        end_sim();
    end
endmodule : frs_status_tb_top
